//--- pwm_channel_pkg.sv
package pwm_channel_pkg;

  // register indices on the plain register port (word addresses)
  localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_PERIOD = 2'h1;
  localparam logic [1:0] ADDR_WIDTH = 2'h2;
  localparam logic [1:0] ADDR_COUNTER = 2'h3;

  // status/interrupt/control field positions
  localparam int BIT_FLAG = 15;
  localparam int BIT_PIN = 7;
  localparam int BIT_LOAD = 6;
  localparam int BIT_POL = 5;
  localparam int BIT_EN = 4;
  localparam int BIT_DIV3 = 3;
  localparam int POS_CLK = 0;
  localparam int POS_IRQ_LEVEL = 8;

  // values after reset
  localparam logic [15:0] COUNTER_START = 16'h0001;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [15:0] WIDTH_RESET = 16'h0000;
  localparam logic [2:0] CLK_RESET = 3'h0;
  localparam logic [2:0] IRQ_LEVEL_RESET = 3'h0;

  // prescaler chain length: divide-by-256 stage plus the x2 tap for code 111
  localparam int PRESCALE_BITS = 9;

  // control fields travelling together
  typedef struct packed {
    logic enable;
    logic polarity;
    logic div3Select;
    logic [2:0] clockSelect;
    logic [2:0] irqLevel;
  } control_type;

endpackage

//--- pwm_prescaler.sv
`timescale 1ns/1ps
// divide-by-2-or-3 first stage followed by a binary chain; one-cycle tick out
module pwm_prescaler
  import pwm_channel_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic div3Select,
  input wire logic [2:0] clockSelect,
  output logic tick
);

  logic [1:0] firstCount;
  logic firstTick;
  logic [PRESCALE_BITS-1:0] chain;
  logic [PRESCALE_BITS-1:0] next_chain;
  logic [3:0] tap;

  // first stage: f/2 or f/3, held in reset while stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      firstCount <= 2'h0;
    end else if (!run) begin
      firstCount <= 2'h0;
    end else if (firstTick) begin
      firstCount <= 2'h0;
    end else begin
      firstCount <= firstCount + 2'h1;
    end
  end

  assign firstTick = run && (firstCount == (div3Select ? 2'h2 : 2'h1));

  // binary chain advanced by first-stage ticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain <= '0;
    end else if (!run) begin
      chain <= '0;
    end else if (firstTick) begin
      chain <= next_chain;
    end
  end

  assign next_chain = chain + PRESCALE_BITS'(1);

  // divisor tap choice
  // code 111 skips a stage: 2^8 rather than 2^7 first-stage ticks
  always_comb begin
    tap = (clockSelect == 3'h7) ? 4'h8 : {1'b0, clockSelect};
  end

  // tick when every chain bit below the tap is one, so the rate changes cleanly
  always_comb begin
    tick = firstTick;
    for (int i = 0; i < PRESCALE_BITS; i++) begin
      if (i < int'(tap) && !chain[i]) begin
        tick = 1'b0;
      end
    end
  end

endmodule

//--- pwm_compare.sv
`timescale 1ns/1ps
// equality comparator, quiet while the channel is disabled
module pwm_compare #(
  parameter int WIDTH = 16
) (
  input wire logic active,
  input wire logic [WIDTH-1:0] counter,
  input wire logic [WIDTH-1:0] reference,
  output logic match
);

  assign match = active && (counter == reference);

endmodule

//--- pwm_submodule_channel.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// - disabled: output flip-flop reset, pin at polarity level
// - enabled: pulse starts at period start, ends at variable edge; polarity inverts
// - disabled: prescaler held in reset, comparators inactive
// - disabled: counter stopped at one
// - disabled: buffers follow period and width registers continuously
// - enable rising: set output, release prescaler, count from one, set flag
// - enabled: waveform from buffers, refreshed at each period end
// - clock-rate field picks one of eight prescaler taps, changeable anytime
// - divisors 2..128 and 512, or 3..192 and 768 with div-3
// - enabled: period buffer loads at period end or on load bit
// - disabled: period write reaches buffer next cycle
// - enabled: width buffer loads at period end or on load bit
// - disabled: width write reaches buffer next cycle
// - period register changes only by software writes
// - width register changes only by software writes
// - counter register reads current count, writes ignored
// - counter one after reset and held at one while disabled
// - flag set per period; cleared by read-as-one then write zero
// - load bit reloads buffers, counter, flag, output; reads zero
// - nonzero interrupt level raises request when flag sets
// - pin status bit reflects the output pin, read-only
module pwm_submodule_channel
  import pwm_channel_pkg::*;
#(
  parameter int DATA_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] address,
  input wire logic [15:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [15:0] readData,
  output logic pwmOut,
  output logic [2:0] irqRequest
);

  control_type control;
  logic [DATA_WIDTH-1:0] periodRegister;
  logic [DATA_WIDTH-1:0] widthRegister;
  logic [DATA_WIDTH-1:0] periodBuffer;
  logic [DATA_WIDTH-1:0] widthBuffer;
  logic [DATA_WIDTH-1:0] counter;
  logic outputFlop;
  logic flag;
  logic flagSeenSet;
  logic enableDelayed;
  logic counterTick;
  logic periodMatch;
  logic widthMatch;
  logic enableRise;
  logic loadPulse;
  logic periodEnd;
  logic writeControl;
  logic [DATA_WIDTH-1:0] next_widthBuffer;

  assign writeControl = writeStrobe && (address == ADDR_STATUS_CONTROL);
  assign enableRise = control.enable && !enableDelayed;
  // a load written while disabled does nothing
  assign loadPulse = writeControl && writeData[BIT_LOAD] && control.enable;

  // prescaler reset
  // held through the enable-rise cycle too, so the first tick is a full divisor after count one
  pwm_prescaler u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .run(control.enable && !enableRise),
    .div3Select(control.div3Select),
    .clockSelect(control.clockSelect),
    .tick(counterTick)
  );

  pwm_compare #(.WIDTH(DATA_WIDTH)) u_period_compare (
    .active(control.enable),
    .counter(counter),
    .reference(periodBuffer),
    .match(periodMatch)
  );

  pwm_compare #(.WIDTH(DATA_WIDTH)) u_width_compare (
    .active(control.enable),
    .counter(counter),
    .reference(widthBuffer),
    .match(widthMatch)
  );

  assign periodEnd = counterTick && periodMatch && !loadPulse;

  // control register fields; the load bit is a strobe, never stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= '{enable: 1'b0, polarity: 1'b0, div3Select: 1'b0,
                   clockSelect: CLK_RESET, irqLevel: IRQ_LEVEL_RESET};
    end else if (writeControl) begin
      control.enable <= writeData[BIT_EN];
      control.polarity <= writeData[BIT_POL];
      control.div3Select <= writeData[BIT_DIV3];
      control.clockSelect <= writeData[POS_CLK +: 3];
      control.irqLevel <= writeData[POS_IRQ_LEVEL +: 3];
    end
  end

  // edge detector for enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enableDelayed <= 1'b0;
    end else begin
      enableDelayed <= control.enable;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periodRegister <= PERIOD_RESET;
    end else if (writeStrobe && address == ADDR_PERIOD) begin
      periodRegister <= writeData[DATA_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      widthRegister <= WIDTH_RESET;
    end else if (writeStrobe && address == ADDR_WIDTH) begin
      widthRegister <= writeData[DATA_WIDTH-1:0];
    end
  end

  // buffers follow while disabled; one cycle late, as a write lands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periodBuffer <= PERIOD_RESET;
    end else if (!control.enable || loadPulse || periodEnd) begin
      periodBuffer <= periodRegister;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      widthBuffer <= WIDTH_RESET;
    end else if (!control.enable || loadPulse || periodEnd) begin
      widthBuffer <= widthRegister;
    end
  end

  assign next_widthBuffer = widthRegister;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter <= COUNTER_START;
    end else if (!control.enable || loadPulse || enableRise) begin
      counter <= COUNTER_START;
    end else if (counterTick) begin
      if (periodMatch) begin
        counter <= COUNTER_START;
      end else begin
        counter <= counter + DATA_WIDTH'(1);
      end
    end
  end

  // output flip-flop; width match yields to disable, enable rise, load and a new period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outputFlop <= 1'b0;
    end else if (!control.enable) begin
      outputFlop <= 1'b0;
    end else if (enableRise) begin
      outputFlop <= 1'b1;
    end else if (loadPulse) begin
      outputFlop <= (next_widthBuffer != '0);
    end else if (periodEnd) begin
      outputFlop <= (widthRegister != '0);
    end else if (counterTick && widthMatch) begin
      outputFlop <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwmOut <= 1'b0;
    end else if (!control.enable) begin
      pwmOut <= control.polarity;
    end else begin
      pwmOut <= outputFlop ^ control.polarity;
    end
  end

  // flag set wins over a clear
  // a clear only counts after a read that saw the flag set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
      flagSeenSet <= 1'b0;
    end else if (!control.enable && !enableRise) begin
      flag <= 1'b0;
      flagSeenSet <= 1'b0;
    end else if (enableRise || loadPulse || periodEnd) begin
      flag <= 1'b1;
    end else begin
      if (readStrobe && address == ADDR_STATUS_CONTROL && flag) begin
        flagSeenSet <= 1'b1;
      end
      if (writeControl && !writeData[BIT_FLAG] && flagSeenSet) begin
        flag <= 1'b0;
        flagSeenSet <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqRequest <= 3'h0;
    end else begin
      irqRequest <= flag ? control.irqLevel : 3'h0;
    end
  end

  // register read path, data in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readData <= 16'h0000;
    end else if (readStrobe) begin
      unique case (address)
        ADDR_STATUS_CONTROL: begin
          readData <= {flag, 4'h0, control.irqLevel, pwmOut, 1'b0, control.polarity,
                       control.enable, control.div3Select, control.clockSelect};
        end
        ADDR_PERIOD: readData <= 16'(periodRegister);
        ADDR_WIDTH: readData <= 16'(widthRegister);
        ADDR_COUNTER: readData <= 16'(counter);
      endcase
    end else begin
      readData <= 16'h0000;
    end
  end

  sequence s_enable_rise;
    control.enable && !enableDelayed;
  endsequence

  sequence s_pulse_started;
    ##1 (outputFlop && flag && counter == COUNTER_START);
  endsequence

  property p_disabled_pin;
    @(posedge clk) disable iff (!reset_n)
      !control.enable |=> (pwmOut == $past(control.polarity));
  endproperty
  a_disabled_pin: assert property (p_disabled_pin) else $error("pin not at polarity");

  property p_enable_start;
    @(posedge clk) disable iff (!reset_n)
      s_enable_rise |-> s_pulse_started;
  endproperty
  a_enable_start: assert property (p_enable_start) else $error("enable start wrong");

  property p_counter_held;
    @(posedge clk) disable iff (!reset_n)
      !control.enable |=> counter == COUNTER_START;
  endproperty
  a_counter_held: assert property (p_counter_held) else $error("counter not one");

  property p_buffer_follow;
    @(posedge clk) disable iff (!reset_n)
      !control.enable |=> periodBuffer == $past(periodRegister)
        && widthBuffer == $past(widthRegister);
  endproperty
  a_buffer_follow: assert property (p_buffer_follow) else $error("buffers stale");

  property p_period_end;
    @(posedge clk) disable iff (!reset_n)
      (control.enable && counterTick && periodMatch && !loadPulse && !enableRise)
        |=> counter == COUNTER_START && flag;
  endproperty
  a_period_end: assert property (p_period_end) else $error("period end wrong");

  property p_width_edge;
    @(posedge clk) disable iff (!reset_n)
      (control.enable && counterTick && widthMatch && !periodMatch && !loadPulse
        && !enableRise) |=> !outputFlop;
  endproperty
  a_width_edge: assert property (p_width_edge) else $error("no variable edge");

  property p_load;
    @(posedge clk) disable iff (!reset_n)
      loadPulse |=> flag && counter == COUNTER_START && periodBuffer == $past(periodRegister);
  endproperty
  a_load: assert property (p_load) else $error("load incomplete");

  property p_irq;
    @(posedge clk) disable iff (!reset_n)
      flag && control.irqLevel != 3'h0 |=> irqRequest == $past(control.irqLevel);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");

  property p_prescaler_idle;
    @(posedge clk) disable iff (!reset_n)
      !control.enable |-> !counterTick && !periodMatch && !widthMatch;
  endproperty
  a_prescaler_idle: assert property (p_prescaler_idle) else $error("active while off");

  sequence s_status_read;
    readStrobe && address == ADDR_STATUS_CONTROL;
  endsequence

  property p_flag_hold;
    @(posedge clk) disable iff (!reset_n)
      flag && control.enable && !writeControl |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_buffer_hold;
    @(posedge clk) disable iff (!reset_n)
      control.enable && !loadPulse && !periodEnd
        |=> $stable(periodBuffer) && $stable(widthBuffer);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("buffer moved mid-period");

  property p_status_read;
    @(posedge clk) disable iff (!reset_n)
      s_status_read |=> readData[BIT_PIN] == $past(pwmOut) && !readData[BIT_LOAD];
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bits wrong");

  property p_counter_read;
    @(posedge clk) disable iff (!reset_n)
      readStrobe && address == ADDR_COUNTER |=> readData == $past(counter);
  endproperty
  a_counter_read: assert property (p_counter_read) else $error("counter read wrong");

endmodule

//--- pwm_load_model.sv
`timescale 1ns/1ps
// load on the pin: times the last period and last high run in clocks
module pwm_load_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output int lastPeriod,
  output int lastHigh,
  output int rises
);
  logic prev;
  int sinceRise;
  int highRun;

  // edge timing; counts restart at reset so reset glitches are not measured
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b0;
      sinceRise <= 0;
      highRun <= 0;
      lastPeriod <= 0;
      lastHigh <= 0;
      rises <= 0;
    end else begin
      prev <= pin;
      if (pin && !prev) begin
        lastPeriod <= sinceRise;
        sinceRise <= 1;
        rises <= rises + 1;
      end else begin
        sinceRise <= sinceRise + 1;
      end
      if (pin) begin
        highRun <= prev ? highRun + 1 : 1;
      end
      if (!pin && prev) begin
        lastHigh <= highRun;
      end
    end
  end
endmodule

//--- pwm_submodule_channel_test.sv
`timescale 1ns/1ps
module pwm_submodule_channel_test;
  import pwm_channel_pkg::*;
  typedef struct {
    logic isWrite;
    logic [1:0] addr;
    logic [15:0] data;
  } row_type;
  logic clk;
  logic reset_n;
  logic [1:0] address;
  logic [15:0] writeData;
  logic writeStrobe;
  logic readStrobe;
  logic [15:0] readData;
  logic pwmOut;
  logic [2:0] irqRequest;
  logic [15:0] value;
  int lastPeriod;
  int lastHigh;
  int rises;
  int mismatches = 0;
  int comparisons = 0;
  int d;
  // plain register traffic while disabled; reads carry the expected word
  row_type rows [10] = '{
    '{1'b1, ADDR_PERIOD, 16'h1234}, '{1'b0, ADDR_PERIOD, 16'h1234},
    '{1'b1, ADDR_WIDTH, 16'hABCD}, '{1'b0, ADDR_WIDTH, 16'hABCD},
    '{1'b1, ADDR_COUNTER, 16'h5555}, '{1'b0, ADDR_COUNTER, 16'h0001},
    '{1'b1, ADDR_STATUS_CONTROL, 16'h03E5}, '{1'b0, ADDR_STATUS_CONTROL, 16'h03A5},
    '{1'b1, ADDR_STATUS_CONTROL, 16'h0000}, '{1'b0, ADDR_STATUS_CONTROL, 16'h0000}};

  pwm_submodule_channel DUT (
    .clk(clk), .reset_n(reset_n), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .pwmOut(pwmOut), .irqRequest(irqRequest));

  pwm_load_model load (
    .clk(clk), .reset_n(reset_n), .pin(pwmOut),
    .lastPeriod(lastPeriod), .lastHigh(lastHigh), .rises(rises));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    comparisons++;
    if (seen !== expected) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    address <= a;
    writeData <= v;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1;
    v = readData;
  endtask

  // bounded wait so a dead pin cannot hang the run
  task automatic waitRises(input int n);
    int start;
    int guard;
    start = rises;
    guard = 0;
    while (rises < start + n && guard < 12000) begin
      @(posedge clk);
      guard++;
    end
  endtask

  // counter clock divisor per clock-rate code, with the divide-by-three option
  function automatic int divisor(input logic [2:0] code, input logic div3);
    int r;
    r = (code == 3'h7) ? 512 : (2 << code);
    if (div3) begin
      r = r * 3 / 2;
    end
    return r;
  endfunction

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    address = 2'h0;
    writeData = 16'h0000;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_COUNTER, value);
    check(value, COUNTER_START);
    check({15'h0000, pwmOut}, 16'h0000);
    $display("test reset done");
    // register rows, with idle cycles so the pin status settles
    foreach (rows[i]) begin
      if (rows[i].isWrite) begin
        wr(rows[i].addr, rows[i].data);
        repeat (3) @(posedge clk);
      end else begin
        rd(rows[i].addr, value);
        check(value, rows[i].data);
      end
    end
    $display("test registers done");
    // every clock code, both prescaler options; polarity follows div3
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_PERIOD, 16'h0003);
      wr(ADDR_WIDTH, 16'h0001);
      wr(ADDR_STATUS_CONTROL, {10'h000, i[3], 1'b1, i[3], i[2:0]});
      waitRises(3);
      d = divisor(i[2:0], i[3]);
      check(16'(lastPeriod), 16'(3 * d));
      check(16'(lastHigh), 16'(i[3] ? 2 * d : d));
      wr(ADDR_STATUS_CONTROL, 16'h0000);
    end
    $display("test waveform done");
    // long period so no completion happens during the flag steps
    wr(ADDR_PERIOD, 16'h03E8);
    wr(ADDR_WIDTH, 16'h01F4);
    wr(ADDR_STATUS_CONTROL, 16'h0510);
    repeat (2) @(posedge clk);
    rd(ADDR_STATUS_CONTROL, value);
    check(value, 16'h8590);
    check({13'h0000, irqRequest}, 16'h0005);
    wr(ADDR_STATUS_CONTROL, 16'h0510);
    rd(ADDR_STATUS_CONTROL, value);
    check(value, 16'h0590);
    check({13'h0000, irqRequest}, 16'h0000);
    wr(ADDR_STATUS_CONTROL, 16'h8510);
    rd(ADDR_STATUS_CONTROL, value);
    check(value, 16'h0590);
    $display("test flag done");
    // new values wait for the period end; the old period keeps counting
    wr(ADDR_PERIOD, 16'h0004);
    wr(ADDR_WIDTH, 16'h0002);
    repeat (10) @(posedge clk);
    rd(ADDR_COUNTER, value);
    check({15'h0000, value > 16'h0004}, 16'h0001);
    check({15'h0000, pwmOut}, 16'h0001);
    wr(ADDR_STATUS_CONTROL, 16'h0550);
    rd(ADDR_COUNTER, value);
    check({15'h0000, value < 16'h0004}, 16'h0001);
    rd(ADDR_STATUS_CONTROL, value);
    check(value & 16'hFF7F, 16'h8510);
    waitRises(3);
    check(16'(lastPeriod), 16'h0008);
    check(16'(lastHigh), 16'h0004);
    $display("test load done");
    // glitch-free stop: a period of zero width before the enable is cleared
    wr(ADDR_WIDTH, 16'h0000);
    repeat (20) @(posedge clk);
    check({15'h0000, pwmOut}, 16'h0000);
    wr(ADDR_STATUS_CONTROL, 16'h0000);
    repeat (20) @(posedge clk);
    check({15'h0000, pwmOut}, 16'h0000);
    check({13'h0000, irqRequest}, 16'h0000);
    rd(ADDR_COUNTER, value);
    check(value, 16'h0001);
    rd(ADDR_STATUS_CONTROL, value);
    check(value, 16'h0000);
    $display("test disable done");
    // reset in mid-run with the pin toggling and the request raised
    wr(ADDR_WIDTH, 16'h0002);
    wr(ADDR_STATUS_CONTROL, 16'h0530);
    waitRises(2);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({13'h0000, irqRequest}, 16'h0000);
    check({15'h0000, pwmOut}, 16'h0000);
    @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_COUNTER, value);
    check(value, COUNTER_START);
    rd(ADDR_STATUS_CONTROL, value);
    check(value, 16'h0000);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
